// ---- hw/scd_pkg.sv ----
`default_nettype none
package scd_pkg;
    // ========================================
    // command word layout
    localparam int WORD_BITS = 22;
    localparam int ADDR_LSB = 18;
    localparam int ADDR_W = 4;
    localparam int KIND_LSB = 16;
    localparam int KIND_W = 2;
    localparam int SUB_LSB = 12;
    localparam int SUB_W = 4;
    localparam int DATA_LSB = 0;
    localparam int DATA_W = 12;
    localparam int ELEMS = 16;
    localparam int CNT_W = 5;

    // ========================================
    // output kinds
    localparam logic [KIND_W-1:0] KIND_ANALOG = 2'h0;
    localparam logic [KIND_W-1:0] KIND_RELAY = 2'h1;
    localparam logic [KIND_W-1:0] KIND_LOOSE = 2'h2;
    localparam logic [KIND_W-1:0] KIND_SOLID = 2'h3;

    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DOC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOOSE_MS = 10;
    localparam int TMR_W = 15;

    // ========================================
    // types
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_SHIFT = 5'h02,
        S_CLASSIFY = 5'h04,
        S_DECODE = 5'h08,
        S_GATE = 5'h10
    } scd_state_e;

    typedef struct packed {
        logic c1, c2, cp;
        logic d1, d2;
        logic f1, f2, fp;
    } scd_sync_s;

    typedef struct packed {
        logic [ELEMS-1:0] relay;
        logic [ELEMS-1:0] loose;
        logic [ELEMS-1:0] solid;
        logic [SUB_W-1:0] an_sel;
        logic [DATA_W-1:0] an_val;
        logic an_load;
        logic done;
        logic drop;
    } scd_out_s;

    typedef struct packed {
        scd_state_e st;
        scd_sync_s sy;
        logic [WORD_BITS-1:0] shreg;
        logic [CNT_W-1:0] bitcnt;
        logic overrun;
        logic [KIND_W-1:0] kind;
        logic [ELEMS-1:0] elem;
        logic [DATA_W-1:0] ms_left;
        logic [TMR_W-1:0] cyc;
        scd_out_s o;
    } scd_regs_s;

    localparam scd_regs_s RST_VAL = '{st: S_IDLE, default: '0};
endpackage : scd_pkg
`default_nettype wire

// ---- hw/scd_decoder.sv ----
// What this block does
// - take serial command words from the computer and interpret each one
// - outputs change only in answer to a received command, or when a pulse timer runs out and clears the loose and solid lines
// - act only on own unit address; select the targeted output element
// - classify each command as analog or bilevel before further decoding
// - analog and all bilevel commands (relay, loose, solid) decode the subaddress
// - gate result onto outputs only after all decoding has finished
// - loose bilevel pulses and millisecond-timed solid-state load pulses
// - relay outputs latch, changed only by set and reset commands
`timescale 1ns/1ps
`default_nettype none
module scd_decoder
    import scd_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DOC,
    parameter logic [ADDR_W-1:0] UNIT_ADDR = 4'h1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // serial command pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_frame,
    // stimulus outputs
    output var scd_out_s out
);

    // ========================================
    // parameter check
    if (MS_CYCLES < 1 || MS_CYCLES >= (1 << TMR_W)) begin : g_ms_range
        $error("MS_CYCLES out of range");
    end

    // all checks below run on core_clk and rest while reset is high
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    scd_regs_s r;
    scd_regs_s next_r;

    logic clk_rise;
    logic frame_rise;
    logic frame_fall;
    logic word_full;
    logic [ADDR_W-1:0] w_addr;
    logic [KIND_W-1:0] w_kind;
    logic [SUB_W-1:0] w_sub;
    logic [DATA_W-1:0] w_data;

    assign clk_rise = r.sy.c2 & ~r.sy.cp;
    assign frame_rise = r.sy.f2 & ~r.sy.fp;
    assign frame_fall = ~r.sy.f2 & r.sy.fp;
    assign word_full = (r.bitcnt == CNT_W'(WORD_BITS));
    assign w_addr = r.shreg[ADDR_LSB +: ADDR_W];
    assign w_kind = r.shreg[KIND_LSB +: KIND_W];
    assign w_sub = r.shreg[SUB_LSB +: SUB_W];
    assign w_data = r.shreg[DATA_LSB +: DATA_W];

    // ========================================
    // next state
    always_comb begin
        next_r = r;
        next_r.sy.c1 = ser_clk;
        next_r.sy.c2 = r.sy.c1;
        next_r.sy.cp = r.sy.c2;
        next_r.sy.d1 = ser_data;
        next_r.sy.d2 = r.sy.d1;
        next_r.sy.f1 = ser_frame;
        next_r.sy.f2 = r.sy.f1;
        next_r.sy.fp = r.sy.f2;
        next_r.o.an_load = 1'h0;
        next_r.o.done = 1'h0;
        next_r.o.drop = 1'h0;

        // pulse timer for both bilevel pulse kinds
        if (r.ms_left != '0) begin
            if (r.cyc == TMR_W'(MS_CYCLES - 1)) begin
                next_r.cyc = '0;
                next_r.ms_left = r.ms_left - 12'h001;
                if (r.ms_left == 12'h001) begin
                    next_r.o.loose = '0;
                    next_r.o.solid = '0;
                end
            end else begin
                next_r.cyc = r.cyc + 15'h0001;
            end
        end

        case (r.st)
            S_IDLE: begin
                if (frame_rise) begin
                    next_r.st = S_SHIFT;
                    next_r.bitcnt = '0;
                    next_r.overrun = 1'h0;
                end
            end
            S_SHIFT: begin
                if (clk_rise && r.sy.f2) begin
                    if (word_full) begin
                        next_r.overrun = 1'h1;
                    end else begin
                        next_r.shreg = {r.shreg[WORD_BITS-2:0], r.sy.d2};
                        next_r.bitcnt = r.bitcnt + 5'h01;
                    end
                end
                if (frame_fall) begin
                    if (word_full && !r.overrun && w_addr == UNIT_ADDR) begin
                        next_r.st = S_CLASSIFY;
                    end else begin
                        next_r.st = S_IDLE;
                        next_r.o.drop = !(word_full && !r.overrun);
                    end
                end
            end
            S_CLASSIFY: begin
                next_r.kind = w_kind;
                next_r.st = S_DECODE;
            end
            S_DECODE: begin
                // element select from subaddress
                next_r.elem = {{(ELEMS-1){1'h0}}, 1'h1} << w_sub;
                next_r.st = S_GATE;
            end
            S_GATE: begin
                next_r.st = S_IDLE;
                next_r.o.done = 1'h1;
                case (r.kind)
                    KIND_ANALOG: begin
                        next_r.o.an_sel = w_sub;
                        next_r.o.an_val = w_data;
                        next_r.o.an_load = 1'h1;
                    end
                    KIND_RELAY: begin
                        if (w_data[0])
                            next_r.o.relay = r.o.relay | r.elem;
                        else
                            next_r.o.relay = r.o.relay & ~r.elem;
                    end
                    KIND_LOOSE: begin
                        next_r.o.loose = r.elem;
                        next_r.o.solid = '0;
                        next_r.ms_left = DATA_W'(LOOSE_MS);
                        next_r.cyc = '0;
                    end
                    default: begin
                        // zero duration leaves the lines untouched
                        if (w_data != '0) begin
                            next_r.o.solid = r.elem;
                            next_r.o.loose = '0;
                            next_r.ms_left = w_data;
                            next_r.cyc = '0;
                        end
                    end
                endcase
            end
            default: begin
                next_r.st = S_IDLE;
            end
        endcase
    end

    // ========================================
    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= RST_VAL;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign out = r.o;

    // ========================================
    // checks
    take_word_a: assert property (ce && r.st == S_SHIFT
        && frame_fall && word_full && !r.overrun && w_addr == UNIT_ADDR
        |=> r.st == S_CLASSIFY)
        else $error("complete addressed word not taken");

    load_cause_a: assert property ($rose(r.o.an_load)
        |-> $past(r.st) == S_GATE && $past(r.kind) == KIND_ANALOG)
        else $error("analog load without command");

    addr_match_a: assert property (r.st == S_CLASSIFY
        |-> w_addr == UNIT_ADDR)
        else $error("foreign address decoded");

    foreign_quiet_a: assert property (ce && r.st == S_SHIFT
        && frame_fall && word_full && !r.overrun && w_addr != UNIT_ADDR
        |=> r.st == S_IDLE && !r.o.drop)
        else $error("foreign word not ignored");

    classify_first_a: assert property (r.st == S_DECODE
        && $past(r.st) != S_DECODE
        |-> $past(r.st) == S_CLASSIFY && r.kind == w_kind)
        else $error("decode before classify");

    subaddr_sel_a: assert property (r.st == S_GATE
        |-> $onehot(r.elem) && r.elem[w_sub])
        else $error("element select mismatch");

    gate_order_a: assert property (r.st == S_GATE
        && $past(r.st) != S_GATE |-> $past(r.st) == S_DECODE)
        else $error("gating before decode done");

    pulse_timed_a: assert property (r.o.solid != '0
        || r.o.loose != '0 |-> r.ms_left != '0)
        else $error("pulse line without timer");

    pulse_line_a: assert property (r.o.solid != '0
        |-> r.o.loose == '0 && $onehot(r.o.solid))
        else $error("solid pulse line not single");

    relay_hold_a: assert property (!(ce && r.st == S_GATE
        && r.kind == KIND_RELAY) |=> $stable(r.o.relay))
        else $error("relay changed without command");

    short_drop_a: assert property (ce && r.st == S_SHIFT
        && frame_fall && !word_full |=> r.st == S_IDLE && r.o.drop)
        else $error("incomplete word not dropped");

    long_drop_a: assert property (ce && r.st == S_SHIFT
        && frame_fall && r.overrun |=> r.st == S_IDLE && r.o.drop)
        else $error("overlong word not dropped");

    // clock enable low must freeze every register, synchronisers too
    ce_freeze_a: assert property (!ce |=> $stable(r))
        else $error("state moved with clock enable low");

endmodule : scd_decoder
`default_nettype wire

// ---- tb/scd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========================================
// computer side serial command sender
module scd_host_model
    import scd_pkg::*;
(
    // control from bench
    input wire logic core_clk,
    input wire logic start,
    input wire logic [WORD_BITS:0] word,
    input wire logic [CNT_W-1:0] nbits,
    output logic busy,
    // serial pins
    output logic ser_clk,
    output logic ser_data,
    output logic ser_frame
);
    initial begin
        busy = 0;
        ser_clk = 0;
        ser_data = 0;
        ser_frame = 0;
        forever begin
            @(posedge core_clk);
            if (start) begin
                busy <= 1;
                ser_frame <= 1;
                for (int i = int'(nbits) - 1; i >= 0; i--) begin
                    ser_data <= word[i];
                    repeat (4) @(posedge core_clk);
                    ser_clk <= 1;
                    repeat (4) @(posedge core_clk);
                    ser_clk <= 0;
                end
                ser_frame <= 0;
                // released data line shows the inverse, not a held value
                ser_data <= ~ser_data;
                repeat (8) @(posedge core_clk);
                busy <= 0;
            end
        end
    end
endmodule : scd_host_model
`default_nettype wire

// ---- tb/scd_decoder_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module scd_decoder_test
    import scd_pkg::*;
;
    logic core_clk = 0, rst = 1, ce = 1, start = 0;
    logic [WORD_BITS:0] word = '0;
    logic [CNT_W-1:0] nbits = '0;
    logic busy, ser_clk, ser_data, ser_frame;
    logic got_done = 0, got_drop = 0;
    scd_out_s out;
    int miscompares = 0, n_compared = 0, n;
    // cycles per ms in simulation, kept short so pulses fit the run
    localparam int MS_SIM = 4;

    scd_decoder #(.MS_CYCLES(MS_SIM), .UNIT_ADDR(4'h1)) i_scd_decoder (
        .core_clk(core_clk), .rst(rst), .ce(ce), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_frame(ser_frame), .out(out));
    scd_host_model i_scd_host_model (
        .core_clk(core_clk), .start(start), .word(word), .nbits(nbits),
        .busy(busy), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_frame(ser_frame));

    initial forever #25 core_clk = ~core_clk;

    task automatic check(input string what, input logic [127:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    // ========================================
    // one command word, then wait for done or drop
    task automatic send(input logic [3:0] a, input logic [1:0] k,
            input logic [3:0] s, input logic [11:0] d, input int nb);
        for (int i = 0; i < 300 && busy !== 1'b0; i++) tick();
        @(posedge core_clk);
        word <= {1'b0, a, k, s, d};
        nbits <= nb[CNT_W-1:0];
        start <= 1;
        @(posedge core_clk);
        start <= 0;
        got_done = 0;
        got_drop = 0;
        for (int i = 0; i < 300 && !got_done && !got_drop; i++) begin
            tick();
            got_done = out.done;
            got_drop = out.drop;
        end
    endtask : send

    task automatic t_relay();
        send(4'h1, KIND_RELAY, 4'h3, 12'h001, 22);
        check("done", got_done, 1);
        check("relay", out.relay, 16'h0008);
        send(4'h1, KIND_RELAY, 4'hf, 12'h001, 22);
        send(4'h1, KIND_RELAY, 4'h3, 12'h000, 22);
        check("relay", out.relay, 16'h8000);
        send(4'h2, KIND_RELAY, 4'h0, 12'h001, 22);
        check("done", got_done, 0);
        check("drop", got_drop, 0);
        check("relay", out.relay, 16'h8000);
        $display("relay test over");
    endtask : t_relay

    task automatic t_analog();
        send(4'h1, KIND_ANALOG, 4'h5, 12'habc, 22);
        check("an_sel", out.an_sel, 4'h5);
        check("an_val", out.an_val, 12'habc);
        check("an_load", out.an_load, 1);
        check("relay", out.relay, 16'h8000);
        $display("analog test over");
    endtask : t_analog

    task automatic t_pulse(input logic [1:0] k, input logic [3:0] s,
            input logic [11:0] d, input int cyc);
        send(4'h1, k, s, d, 22);
        check("line", out.loose | out.solid, 16'h1 << s);
        for (n = 0; n < 200 && (out.loose | out.solid) !== 0; n++) tick();
        check("width", n, cyc);
        $display("pulse test over");
    endtask : t_pulse

    task automatic t_hold();
        send(4'h1, KIND_SOLID, 4'h4, 12'h002, 22);
        @(posedge core_clk);
        ce <= 0;
        repeat (5) @(posedge core_clk);
        ce <= 1;
        #1;
        for (n = 6; n < 200 && out.solid !== 0; n++) tick();
        check("held", n, 2 * MS_SIM + 5);
        send(4'h1, KIND_SOLID, 4'h9, 12'h000, 22);
        check("done", got_done, 1);
        check("line", out.loose | out.solid, 0);
        $display("hold test over");
    endtask : t_hold

    task automatic t_bad();
        send(4'h1, KIND_RELAY, 4'h0, 12'h001, 21);
        check("drop", got_drop, 1);
        send(4'h1, KIND_RELAY, 4'h0, 12'h001, 23);
        check("drop", got_drop, 1);
        check("relay", out.relay, 16'h8000);
        $display("framing test over");
    endtask : t_bad

    task automatic results();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 0;
        repeat (3) tick();
        check("out", out, 0);
        t_relay();
        t_analog();
        t_pulse(KIND_LOOSE, 4'h2, 12'h000, LOOSE_MS * MS_SIM);
        t_pulse(KIND_SOLID, 4'h7, 12'h003, 3 * MS_SIM);
        t_hold();
        t_bad();
        results();
    end

    initial begin
        #1000000;
        miscompares++;
        results();
    end
endmodule : scd_decoder_test
`default_nettype wire
